// ==== design/mfs_regs_pkg.sv ====
// Constants and carrier types for the float-switch and current-monitor register group
package mfs_regs_pkg;

  // Register addresses on the six-bit decoded control-port address
  localparam logic [5:0] ADDR_FLOAT_SWITCH_SETUP = 6'h09;
  localparam logic [5:0] ADDR_FLOAT_SWITCH_DELAY = 6'h0A;
  localparam logic [5:0] ADDR_CURRENT_MONITOR    = 6'h0C;
  localparam logic [5:0] ADDR_REGULATION_MODE    = 6'h0F;

  // Field positions, float_switch_setup
  localparam int CHAIN_LSB      = 0;
  localparam int CHAIN_MSB      = 3;
  localparam int FS_DONE_BIT    = 4;
  localparam int FS_START_BIT   = 5;
  localparam int PEAK_HALF_BIT  = 6;
  localparam int AMP_REDUCE_BIT = 7;

  // Field positions, current_monitor
  localparam int LED_RANGE_LSB  = 0;
  localparam int LED_RANGE_MSB  = 1;
  localparam int IN_RANGE_LSB   = 2;
  localparam int IN_RANGE_MSB   = 3;
  localparam int MON_DONE_BIT   = 4;
  localparam int MON_START_BIT  = 5;

  // Field positions, regulation_mode_status
  localparam int REG_MODE_LSB   = 2;
  localparam int REG_MODE_MSB   = 3;

  // Reset values, and the step count that chain code zero selects
  localparam logic [3:0] CHAIN_RESET     = 4'h8;
  localparam logic [7:0] DELAY_RESET     = 8'h20;
  localparam logic [1:0] RANGE_RESET     = 2'h0;
  localparam logic [4:0] CHAIN_MAX_STEPS = 5'h10;
  localparam logic [7:0] DATA_ZERO       = 8'h00;

  // Index of each done flag in the flag array, and the flag count
  localparam int FLAG_FS  = 0;
  localparam int FLAG_MON = 1;
  localparam int N_FLAGS  = 2;

  typedef enum logic [1:0] {
    MODE_NONE       = 2'b00,
    MODE_BUCK       = 2'b01,
    MODE_BOOST      = 2'b10,
    MODE_BUCK_BOOST = 2'b11
  } reg_mode_t;

  // Led range: 00 target..+25%, 01 above +25%, 10 target..-25%, 11 below -25%
  // Input range: 00 75..90%, 01 90%..limit, 10 60..75%, 11 below 60%
  typedef struct packed {
    logic [1:0] ledCurrentRange;
    logic [1:0] inputCurrentRange;
  } monitor_result_t;

  typedef struct packed {
    logic [4:0] chainStepCount;
    logic [7:0] floatSwitchDelayVal;
    logic       floatSwitchRun;
    logic       peakLimitHalving;
    logic       ampCurrentReduce;
    logic       monitorRun;
  } analog_ctrl_t;

endpackage : mfs_regs_pkg

// ==== design/done_flag.sv ====
// Sticky done flag: set by routine completion, cleared by a new start
`timescale 1ns/10ps
`default_nettype none

module done_flag (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Events
  input  wire logic startWrite,
  input  wire logic completeOk,
  // State
  output var  logic done
);

  wire next_done = completeOk | (done & ~startWrite);

  // Completion in the same cycle as a restart wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= next_done;
    end
  end

endmodule // done_flag

`default_nettype wire

// ==== design/mfs_and_current_monitor_regs.sv ====
// Float-switch, current-monitor and regulation-mode register group
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Chain field sets steps; codes 1-15 literal, zero means 16, reset 8.
// - Float-switch done flag bit 4 reads 1 only after successful completion.
// - Writing float-switch start as 1 clears the float-switch done flag.
// - Host writes start bit 5 to run float switch; resets to 0.
// - Bit 6 set halves peak overcurrent threshold during the routine.
// - Bit 7 set cuts amplifier current to 20% only while routine runs.
// - Eight-bit delay field, read-write, reset pattern 00100000.
// - Read-only LED current range at bits 1:0.
// - Read-only input current range at bits 3:2.
// - Monitor done flag bit 4 reads 1 only after successful monitoring.
// - Writing monitor start as 1 clears the monitor done flag.
// - Host writes start bit 5 to begin monitoring; resets to 0.
// - Read-only regulation mode at bits 3:2; buck 01 is the reset value.
module mfs_and_current_monitor_regs
  import mfs_regs_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Decoded control-port register access
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrite,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regRead,
  output var  logic [DATA_W-1:0] regRdData,
  output var  logic              regRdValid,
  output var  logic              regRdHit,
  // Analog routine interface
  input  wire logic              floatSwitchOk,
  input  wire logic              monitorOk,
  input  wire monitor_result_t   monitorResult,
  input  wire reg_mode_t         regulationModeIn,
  output var  analog_ctrl_t      analogCtrl
);

  ////////////////////////////////////////////////////////////////////////////
  // Field map is fixed to byte-wide registers on a six-bit address
  if (DATA_W != 8 || ADDR_W != 6) begin : g_bad_width
    $error("Register group supports only 8-bit data and 6-bit addresses");
  end

  function automatic logic hitAddr(input logic [ADDR_W-1:0] a, input logic [5:0] ref_a);
    hitAddr = (a == ref_a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire selSetup   = hitAddr(regAddr, ADDR_FLOAT_SWITCH_SETUP);
  wire selDelay   = hitAddr(regAddr, ADDR_FLOAT_SWITCH_DELAY);
  wire selMonitor = hitAddr(regAddr, ADDR_CURRENT_MONITOR);
  wire selMode    = hitAddr(regAddr, ADDR_REGULATION_MODE);
  wire anyHit     = selSetup | selDelay | selMonitor | selMode;

  wire wrSetup    = regWrite & selSetup;
  wire wrDelay    = regWrite & selDelay;
  wire wrMonitor  = regWrite & selMonitor;

  ////////////////////////////////////////////////////////////////////////////
  // Storage: read-write fields, then captured status and done flags
  logic [3:0]      chainStepCode;
  logic            floatSwitchStart;
  logic            peakLimitHalving;
  logic            ampCurrentReduce;
  logic [7:0]      floatSwitchDelayVal;
  logic            monitorStart;
  monitor_result_t monitorStatus;
  reg_mode_t       regulationModeFeedback;
  logic [N_FLAGS-1:0] doneFlags;

  // Only read-write bits are taken from a write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chainStepCode    <= CHAIN_RESET;
      floatSwitchStart <= 1'b0;
      peakLimitHalving <= 1'b0;
      ampCurrentReduce <= 1'b0;
    end else if (wrSetup) begin
      chainStepCode    <= regWrData[CHAIN_MSB:CHAIN_LSB];
      floatSwitchStart <= regWrData[FS_START_BIT];
      peakLimitHalving <= regWrData[PEAK_HALF_BIT];
      ampCurrentReduce <= regWrData[AMP_REDUCE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      floatSwitchDelayVal <= DELAY_RESET;
    end else if (wrDelay) begin
      floatSwitchDelayVal <= regWrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      monitorStart <= 1'b0;
    end else if (wrMonitor) begin
      monitorStart <= regWrData[MON_START_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done flags; restart clears, completion sets
  wire [N_FLAGS-1:0] startWrites;
  wire [N_FLAGS-1:0] completions;

  assign startWrites[FLAG_FS]  = wrSetup & regWrData[FS_START_BIT];
  assign startWrites[FLAG_MON] = wrMonitor & regWrData[MON_START_BIT];
  assign completions[FLAG_FS]  = floatSwitchOk & floatSwitchStart;
  assign completions[FLAG_MON] = monitorOk & monitorStart;

  generate
    for (genvar i = 0; i < N_FLAGS; i++) begin : g_done
      done_flag u_done (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .startWrite (startWrites[i]),
        .completeOk (completions[i]),
        .done       (doneFlags[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status capture: ranges latched when monitoring completes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      monitorStatus <= '{RANGE_RESET, RANGE_RESET};
    end else if (completions[FLAG_MON]) begin
      monitorStatus <= monitorResult;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regulationModeFeedback <= MODE_BUCK;
    end else begin
      regulationModeFeedback <= regulationModeIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive to the analog side
  wire fsRunning = floatSwitchStart & ~doneFlags[FLAG_FS];
  wire [4:0] chainSteps = (chainStepCode == 4'h0) ? CHAIN_MAX_STEPS
                                                  : {1'b0, chainStepCode};
  analog_ctrl_t next_analogCtrl;

  always_comb begin
    next_analogCtrl.chainStepCount      = chainSteps;
    next_analogCtrl.floatSwitchDelayVal = floatSwitchDelayVal;
    next_analogCtrl.floatSwitchRun      = fsRunning;
    next_analogCtrl.peakLimitHalving    = peakLimitHalving & fsRunning;
    next_analogCtrl.ampCurrentReduce    = ampCurrentReduce & fsRunning;
    next_analogCtrl.monitorRun          = monitorStart & ~doneFlags[FLAG_MON];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analogCtrl <= '{{1'b0, CHAIN_RESET}, DELAY_RESET, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      analogCtrl <= next_analogCtrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle after the strobe
  wire [7:0] setupWord   = {ampCurrentReduce, peakLimitHalving, floatSwitchStart,
                            doneFlags[FLAG_FS], chainStepCode};
  wire [7:0] monitorWord = {2'b00, monitorStart, doneFlags[FLAG_MON],
                            monitorStatus.inputCurrentRange,
                            monitorStatus.ledCurrentRange};
  wire [7:0] modeWord    = {4'h0, regulationModeFeedback, 2'b00};
  wire [7:0] readMux     = selSetup   ? setupWord :
                           selDelay   ? floatSwitchDelayVal :
                           selMonitor ? monitorWord :
                           selMode    ? modeWord : DATA_ZERO;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdData  <= DATA_ZERO;
      regRdValid <= 1'b0;
      regRdHit   <= 1'b0;
    end else begin
      regRdData  <= regRead ? readMux : regRdData;
      regRdValid <= regRead;
      regRdHit   <= regRead & anyHit;
    end
  end

endmodule // mfs_and_current_monitor_regs

`default_nettype wire

// ==== sim/analog_routine_model.sv ====
// Behavioural model of the analog routines behind the register group
`timescale 1ns/10ps
`default_nettype none
module analog_routine_model
  import mfs_regs_pkg::*;
#(
  parameter int LAT = 4
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Routine control
  input  wire analog_ctrl_t analogCtrl,
  input  wire logic         stall,
  // Completion, bit 0 float switch, bit 1 monitor
  output var  logic [1:0]   ok
);
  wire logic [1:0] run = {analogCtrl.monitorRun, analogCtrl.floatSwitchRun};
  logic      [7:0] cnt [2];
  // One completion pulse, LAT cycles into a run
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      cnt[i] <= (!rst_n || !run[i] || stall) ? 8'h00 : cnt[i] + 8'h01;
    end
  end
  assign ok = {run[1] && cnt[1] == LAT[7:0], run[0] && cnt[0] == LAT[7:0]};
endmodule  // analog_routine_model
`default_nettype wire

// ==== sim/mfs_regs_assertions.sv ====
// Concurrent checks for the float-switch and current-monitor registers
`timescale 1ns/10ps
`default_nettype none
module mfs_regs_checker
  import mfs_regs_pkg::*;
(
  // Clock and reset
  input wire logic            ref_clk,
  input wire logic            rst_n,
  // Register access
  input wire logic [5:0]      regAddr,
  input wire logic            regWrite,
  input wire logic [7:0]      regWrData,
  input wire logic            regRead,
  input wire logic [7:0]      regRdData,
  input wire logic            regRdValid,
  input wire logic            regRdHit,
  // Routine side
  input wire logic            floatSwitchOk,
  input wire logic            monitorOk,
  input wire monitor_result_t monitorResult,
  input wire reg_mode_t       regulationModeIn,
  input wire analog_ctrl_t    analogCtrl
);
  wire logic       wrSetup = regWrite && regAddr == ADDR_FLOAT_SWITCH_SETUP;
  wire logic       wrDelay = regWrite && regAddr == ADDR_FLOAT_SWITCH_DELAY;
  wire logic       wrMon   = regWrite && regAddr == ADDR_CURRENT_MONITOR;
  wire logic       rdMode  = regRead && regAddr == ADDR_REGULATION_MODE;
  wire logic [4:0] steps   = (regWrData[3:0] == 4'h0) ? CHAIN_MAX_STEPS : {1'b0, regWrData[3:0]};
  // Shadow of the written limit bits, to check the gated outputs against
  logic            peakBit;
  logic            ampBit;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      peakBit <= 1'b0;
      ampBit  <= 1'b0;
    end else if (wrSetup) begin
      peakBit <= regWrData[PEAK_HALF_BIT];
      ampBit  <= regWrData[AMP_REDUCE_BIT];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_chain_decode: assert property (
    $past(wrSetup, 2) |-> analogCtrl.chainStepCount == $past(steps, 2)) else $error("chain steps");
  chk_delay_follow: assert property (
    $past(wrDelay, 2) |-> analogCtrl.floatSwitchDelayVal == $past(regWrData, 2))
    else $error("delay value");
  chk_fs_restart: assert property (
    wrSetup && regWrData[FS_START_BIT] && !floatSwitchOk |=> ##1 analogCtrl.floatSwitchRun)
    else $error("float switch start");
  chk_mon_restart: assert property (
    wrMon && regWrData[MON_START_BIT] && !monitorOk |=> ##1 analogCtrl.monitorRun)
    else $error("monitor start");
  chk_fs_finish: assert property (
    floatSwitchOk && analogCtrl.floatSwitchRun && !wrSetup |=> ##1 !analogCtrl.floatSwitchRun)
    else $error("float switch end");
  chk_mon_finish: assert property (
    monitorOk && analogCtrl.monitorRun && !wrMon |=> ##1 !analogCtrl.monitorRun)
    else $error("monitor end");
  chk_peak_gate: assert property (
    analogCtrl.peakLimitHalving == ($past(peakBit) && analogCtrl.floatSwitchRun))
    else $error("peak limit gate");
  chk_amp_gate: assert property (
    analogCtrl.ampCurrentReduce == ($past(ampBit) && analogCtrl.floatSwitchRun))
    else $error("amp current gate");
  chk_mode_read: assert property (
    rdMode |=> regRdHit && regRdData == {4'h0, $past(regulationModeIn, 2), 2'h0})
    else $error("mode read");
  cover property (floatSwitchOk && analogCtrl.floatSwitchRun);
  cover property (monitorOk && analogCtrl.monitorRun);
  cover property (rdMode);
endmodule  // mfs_regs_checker
bind mfs_and_current_monitor_regs mfs_regs_checker checker_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
  .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
  .regRdHit(regRdHit), .floatSwitchOk(floatSwitchOk), .monitorOk(monitorOk),
  .monitorResult(monitorResult), .regulationModeIn(regulationModeIn), .analogCtrl(analogCtrl));
`default_nettype wire

// ==== sim/mfs_and_current_monitor_regs_bench.sv ====
// Self-checking bench for the float-switch and current-monitor registers
`timescale 1ns/10ps
`default_nettype none
module mfs_and_current_monitor_regs_bench
  import mfs_regs_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [5:0]      regAddr = 6'h00;
  logic            regWrite = 1'b0;
  logic [7:0]      regWrData = 8'h00;
  logic            regRead = 1'b0;
  logic [7:0]      regRdData;
  logic            regRdValid;
  logic            regRdHit;
  wire logic [1:0] okv;
  monitor_result_t monitorResult = '0;
  reg_mode_t       regulationModeIn = MODE_BUCK;
  analog_ctrl_t    analogCtrl;
  logic            stall = 1'b1;
  int              miscompares = 0;
  int              cmp_count = 0;
  logic [7:0]      dly [2] = '{8'h00, 8'hFF};
  reg_mode_t       modes [3] = '{MODE_BOOST, MODE_BUCK_BOOST, MODE_BUCK};
  wire logic [7:0] ctl = {4'h0, analogCtrl.monitorRun, analogCtrl.floatSwitchRun,
                          analogCtrl.peakLimitHalving, analogCtrl.ampCurrentReduce};
  always #5 ref_clk = ~ref_clk;
  mfs_and_current_monitor_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
    .regRdValid(regRdValid), .regRdHit(regRdHit), .floatSwitchOk(okv[0]),
    .monitorOk(okv[1]), .monitorResult(monitorResult), .regulationModeIn(regulationModeIn),
    .analogCtrl(analogCtrl));
  analog_routine_model routine (.ref_clk(ref_clk), .rst_n(rst_n), .analogCtrl(analogCtrl),
    .stall(stall), .ok(okv));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic h);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    chk({6'h00, regRdValid, regRdHit}, {7'h01, h});
    chk(regRdData, e);
    @(posedge ref_clk);
  endtask
  // Lets the routine run, then waits for its completion pulse
  task automatic wait_done(input int m);
    stall <= 1'b0;
    for (int i = 0; i < 20 && okv[m] !== 1'b1; i++) @(negedge ref_clk);
    chk({7'h00, okv[m]}, 8'h01);
    @(posedge ref_clk);
    stall <= 1'b1;
  endtask
  task automatic print_verdict();
    $display("miscompares %0d, comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_FLOAT_SWITCH_SETUP, 8'h08, 1'b1);
    rd(ADDR_CURRENT_MONITOR, 8'h00, 1'b1);
    rd(ADDR_REGULATION_MODE, 8'h04, 1'b1);
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_FLOAT_SWITCH_SETUP, 8'(c));
      rd(ADDR_FLOAT_SWITCH_SETUP, 8'(c), 1'b1);
      chk({3'h0, analogCtrl.chainStepCount}, (c == 0) ? 8'h10 : 8'(c));
    end
    rd(ADDR_FLOAT_SWITCH_DELAY, 8'h20, 1'b1);
    foreach (dly[i]) begin
      wr(ADDR_FLOAT_SWITCH_DELAY, dly[i]);
      rd(ADDR_FLOAT_SWITCH_DELAY, dly[i], 1'b1);
      chk(analogCtrl.floatSwitchDelayVal, dly[i]);
    end
    wr(ADDR_FLOAT_SWITCH_SETUP, 8'h10);
    wr(ADDR_CURRENT_MONITOR, 8'h1F);
    wr(ADDR_REGULATION_MODE, 8'hFF);
    wr(6'h0B, 8'hFF);
    rd(ADDR_FLOAT_SWITCH_SETUP, 8'h00, 1'b1);
    rd(ADDR_CURRENT_MONITOR, 8'h00, 1'b1);
    rd(ADDR_REGULATION_MODE, 8'h04, 1'b1);
    rd(6'h0B, 8'h00, 1'b0);
    wr(ADDR_FLOAT_SWITCH_SETUP, 8'hE3);
    rd(ADDR_FLOAT_SWITCH_SETUP, 8'hE3, 1'b1);
    chk(ctl, 8'h07);
    wait_done(FLAG_FS);
    rd(ADDR_FLOAT_SWITCH_SETUP, 8'hF3, 1'b1);
    chk(ctl, 8'h00);
    wr(ADDR_FLOAT_SWITCH_SETUP, 8'hC3);
    rd(ADDR_FLOAT_SWITCH_SETUP, 8'hD3, 1'b1);
    wr(ADDR_FLOAT_SWITCH_SETUP, 8'hE3);
    rd(ADDR_FLOAT_SWITCH_SETUP, 8'hE3, 1'b1);
    monitorResult <= '{2'b01, 2'b11};
    wr(ADDR_CURRENT_MONITOR, 8'h20);
    rd(ADDR_CURRENT_MONITOR, 8'h20, 1'b1);
    chk(ctl, 8'h0F);
    wait_done(FLAG_MON);
    rd(ADDR_CURRENT_MONITOR, 8'h3D, 1'b1);
    chk(ctl, 8'h00);
    wr(ADDR_CURRENT_MONITOR, 8'h20);
    rd(ADDR_CURRENT_MONITOR, 8'h2D, 1'b1);
    foreach (modes[i]) begin
      regulationModeIn <= modes[i];
      @(posedge ref_clk);
      rd(ADDR_REGULATION_MODE, {4'h0, modes[i], 2'h0}, 1'b1);
    end
    print_verdict();
  end
endmodule  // mfs_and_current_monitor_regs_bench
`default_nettype wire
